// ==== shared/adem_cfg.svh ====
// Constants of the ADC diagnostic error monitor
`ifndef ADEM_CFG_SVH
`define ADEM_CFG_SVH

// ==========================================================
// Register addresses
`define ADEM_ADDR_STATUS 7'h00
`define ADEM_ADDR_ERROR 7'h01
`define ADEM_ADDR_ERREN 7'h02
`define ADEM_ADDR_MCLKCNT 7'h03
`define ADEM_ADDR_RESULT 7'h04
`define ADEM_NUM_REGS 5

// ==========================================================
// Bit positions in error, error enable and status registers
`define ADEM_B_REF_LOSS 0
`define ADEM_B_CONV 1
`define ADEM_B_POS_RANGE 2
`define ADEM_B_NEG_RANGE 3
`define ADEM_B_REF_RANGE 4
`define ADEM_B_SCLK 5
`define ADEM_B_RD 6
`define ADEM_B_WR 7
`define ADEM_B_LOCK 8
`define ADEM_B_CLKMON 9
`define ADEM_B_SUMMARY 0

// ==========================================================
// Reset values and masks
`define ADEM_ERREN_RESET 16'h0100
`define ADEM_ERREN_MASK 16'h03ff
`define ADEM_ERR_MASK 16'h01ff

// ==========================================================
// Counts and limits
`define ADEM_MCLK_DIV 131
`define ADEM_SAT_RUN 20
`define ADEM_OFS_MIN 16'h07ff
`define ADEM_OFS_MAX 16'hf7ff
`define ADEM_CMD_BITS 8
`define ADEM_FRAME_BITS 24
`define ADEM_RD_BIT 7

`endif

// ==== shared/adem_pkg.sv ====
// Types and address decoding of the ADC diagnostic error monitor
`include "adem_cfg.svh"
package adem_pkg;

  // ========================================================
  // Frame tracking states
  typedef enum logic [2:0] {
    ADEM_IDLE = 3'b001,
    ADEM_FRAME = 3'b010,
    ADEM_DONE = 3'b100
  } adem_frame_t;

  // ========================================================
  // Serial link state
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] cmd;
    logic [15:0] data;
  } adem_link_state_t;

  // ========================================================
  // Core state
  typedef struct packed {
    adem_frame_t frame;
    logic cs_s1;
    logic cs_s2;
    logic [7:0] pres;
    logic [15:0] mclk_cnt;
    logic [4:0] sat_cnt;
    logic last_mod;
    logic conv_pend;
    logic gain_ovf;
    logic [15:0] err;
    logic [15:0] erren;
    logic summary;
    logic [15:0] result;
    logic ofs_load;
    logic gain_load;
    logic [`ADEM_NUM_REGS-1:0][15:0] image;
  } adem_core_state_t;

  // ========================================================
  // Address decoding
  function automatic logic adem_readable(input logic [6:0] addr);
    return addr < 7'(`ADEM_NUM_REGS);
  endfunction : adem_readable

  function automatic logic adem_writable(input logic [6:0] addr);
    return (addr == `ADEM_ADDR_ERROR) || (addr == `ADEM_ADDR_ERREN);
  endfunction : adem_writable

endpackage : adem_pkg

// ==== shared/adem_link_if.sv ====
// Carrier between the serial link and the monitor core
`timescale 1ns/10ps
`include "adem_cfg.svh"
interface adem_link_if;
  logic [7:0] cnt;
  logic [7:0] cmd;
  logic [15:0] data;
  logic [`ADEM_NUM_REGS-1:0][15:0] image;

  modport link (output cnt, output cmd, output data, input image);
  modport core (input cnt, input cmd, input data, output image);
endinterface : adem_link_if

// ==== verilog/adem_spi_link.sv ====
// Serial link shifter on the SCLK domain
`timescale 1ns/10ps
`include "adem_cfg.svh"
module adem_spi_link (
  // Serial pins
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic i_rstn,
  output logic o_sdo,
  output logic o_sdo_oe_n,
  // Core side
  adem_link_if.link lif
);

  // ========================================================
  // State
  adem_pkg::adem_link_state_t s, next_s;
  logic in_frame;
  logic frame_clr;
  logic [6:0] addr;
  logic [3:0] bit_idx;
  logic [7:0] rd_pos;

  assign frame_clr = i_cs_n | ~i_rstn;
  assign addr = s.cmd[6:0];

  // ========================================================
  // First edge of a frame restarts the bit count
  always_ff @(posedge i_sclk or posedge frame_clr) begin
    if (frame_clr) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  always_comb begin
    next_s = s;
    if (!in_frame) begin
      next_s.cnt = 8'h01;
      next_s.cmd = {7'h00, i_sdi};
      next_s.data = 16'h0000;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
      if (s.cnt < 8'(`ADEM_CMD_BITS)) begin
        next_s.cmd = {s.cmd[6:0], i_sdi};
      end else if (s.cnt < 8'(`ADEM_FRAME_BITS)) begin
        next_s.data = {s.data[14:0], i_sdi};
      end
    end
  end

  always_ff @(posedge i_sclk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ========================================================
  // Read data out of the frozen register image
  assign rd_pos = s.cnt - 8'(`ADEM_CMD_BITS);
  assign bit_idx = 4'hf - rd_pos[3:0];
  always_comb begin
    o_sdo = 1'b0;
    if (in_frame && s.cmd[`ADEM_RD_BIT] && adem_pkg::adem_readable(addr)
        && s.cnt >= 8'(`ADEM_CMD_BITS)
        && s.cnt < 8'(`ADEM_FRAME_BITS)) begin
      o_sdo = lif.image[addr[2:0]][bit_idx];
    end
  end
  assign o_sdo_oe_n = i_cs_n;

  assign lif.cnt = s.cnt;
  assign lif.cmd = s.cmd;
  assign lif.data = s.data;

endmodule : adem_spi_link

// ==== verilog/adem_monitor.sv ====
// ADC diagnostic error monitor: flags, enables, clock monitor, SPI access
`timescale 1ns/10ps
`include "adem_cfg.svh"
module adem_monitor #(
  parameter int MCLK_DIV = `ADEM_MCLK_DIV,
  parameter int SAT_RUN = `ADEM_SAT_RUN
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Serial interface
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe_n,
  // Reference conditions
  input wire logic i_ref_ext_sel,
  input wire logic i_ref_low,
  input wire logic i_ref_open,
  // Filter and modulator
  input wire logic i_filter_ovf,
  input wire logic i_filter_unf,
  input wire logic i_data_update,
  input wire logic [15:0] i_raw_result,
  input wire logic i_mod_valid,
  input wire logic i_mod_bit,
  // Calibration
  input wire logic i_offset_cal_done,
  input wire logic [15:0] i_offset_coef,
  input wire logic i_gain_cal_active,
  input wire logic i_gain_cal_done,
  // Range comparators
  input wire logic i_pos_over,
  input wire logic i_pos_under,
  input wire logic i_neg_over,
  input wire logic i_neg_under,
  input wire logic i_refp_over,
  input wire logic i_refm_under,
  // Access lock sources
  input wire logic i_defaults_loading,
  input wire logic i_cal_busy,
  input wire logic i_single_seq_busy,
  // Results and status
  output logic [15:0] o_result,
  output logic o_offset_load,
  output logic o_gain_load,
  output logic [15:0] o_error_flags,
  output logic [15:0] o_error_enable,
  output logic o_summary_err,
  output logic [15:0] o_mclk_count,
  output logic o_regs_locked
);

  // ========================================================
  // Parameter check
  initial begin
    if (MCLK_DIV < 2 || MCLK_DIV > 256 || SAT_RUN < 2 || SAT_RUN > 31) begin
      $error("adem_monitor: unsupported MCLK_DIV or SAT_RUN");
    end
  end

  localparam logic [7:0] PRES_LAST = 8'(MCLK_DIV - 1);
  localparam logic [4:0] SAT_LAST = 5'(SAT_RUN - 1);

  // ========================================================
  // Link to the SCLK domain
  adem_link_if lif ();

  adem_spi_link u_link (
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_sdi(i_sdi),
    .i_rstn(i_rstn),
    .o_sdo(o_sdo),
    .o_sdo_oe_n(o_sdo_oe_n),
    .lif(lif)
  );

  // ========================================================
  // State
  adem_pkg::adem_core_state_t s, next_s;

  logic busy;
  logic [15:0] set_v;
  logic [15:0] clr_v;
  logic [6:0] addr;
  logic is_rd;
  logic has_cmd;
  logic wr_full;
  logic wr_ok;
  logic lock_blocks;
  logic mod_sat;
  logic ofs_bad;

  assign busy = i_defaults_loading | i_cal_busy | i_single_seq_busy;
  assign addr = lif.cmd[6:0];
  assign is_rd = lif.cmd[`ADEM_RD_BIT];
  assign has_cmd = lif.cnt >= 8'(`ADEM_CMD_BITS);
  assign wr_full = lif.cnt >= 8'(`ADEM_FRAME_BITS);
  assign mod_sat = i_mod_valid && (i_mod_bit == s.last_mod)
                   && (s.sat_cnt == SAT_LAST);
  assign ofs_bad = (i_offset_coef < `ADEM_OFS_MIN)
                   || (i_offset_coef > `ADEM_OFS_MAX);
  // The error register stays clearable so a set lock flag can be cleared
  assign lock_blocks = s.err[`ADEM_B_LOCK] && addr != `ADEM_ADDR_ERROR;
  assign wr_ok = (s.frame == adem_pkg::ADEM_DONE) && has_cmd && !is_rd
                 && wr_full
                 && adem_pkg::adem_writable(addr)
                 && !busy
                 && !lock_blocks;

  // ========================================================
  // Next state
  always_comb begin
    next_s = s;
    set_v = 16'h0000;
    clr_v = 16'h0000;
    next_s.ofs_load = 1'b0;
    next_s.gain_load = 1'b0;

    // Chip select synchroniser and frame tracking
    next_s.cs_s1 = i_cs_n;
    next_s.cs_s2 = s.cs_s1;
    case (s.frame)
      adem_pkg::ADEM_IDLE: begin
        if (!s.cs_s2) begin
          next_s.frame = adem_pkg::ADEM_FRAME;
        end
      end
      adem_pkg::ADEM_FRAME: begin
        if (s.cs_s2) begin
          next_s.frame = adem_pkg::ADEM_DONE;
        end
      end
      adem_pkg::ADEM_DONE: begin
        next_s.frame = adem_pkg::ADEM_IDLE;
      end
      default: begin
        next_s.frame = adem_pkg::ADEM_IDLE;
      end
    endcase

    // Reference loss
    if (s.erren[`ADEM_B_REF_LOSS] && i_ref_ext_sel
        && (i_ref_low || i_ref_open)) begin
      set_v[`ADEM_B_REF_LOSS] = 1'b1;
    end

    // Modulator run length
    if (i_mod_valid) begin
      next_s.last_mod = i_mod_bit;
      if (i_mod_bit != s.last_mod) begin
        next_s.sat_cnt = 5'h01;
      end else if (s.sat_cnt != SAT_LAST) begin
        next_s.sat_cnt = s.sat_cnt + 5'h01;
      end else begin
        next_s.sat_cnt = 5'h01;
      end
    end

    // Conversion faults wait for the next data update
    if (s.erren[`ADEM_B_CONV] && (i_filter_ovf || i_filter_unf)) begin
      next_s.conv_pend = 1'b1;
    end
    if (s.erren[`ADEM_B_CONV] && mod_sat) begin
      next_s.conv_pend = 1'b1;
    end
    if (i_data_update) begin
      set_v[`ADEM_B_CONV] = s.conv_pend;
      next_s.conv_pend = 1'b0;
      if (s.erren[`ADEM_B_CONV] && i_filter_ovf) begin
        next_s.result = 16'hffff;
      end else if (s.erren[`ADEM_B_CONV] && i_filter_unf) begin
        next_s.result = 16'h0000;
      end else begin
        next_s.result = i_raw_result;
      end
    end

    // Offset calibration
    if (i_offset_cal_done) begin
      if (ofs_bad) begin
        set_v[`ADEM_B_CONV] = s.erren[`ADEM_B_CONV];
      end else begin
        next_s.ofs_load = 1'b1;
      end
    end

    // Gain calibration
    if (i_gain_cal_active && i_filter_ovf) begin
      next_s.gain_ovf = 1'b1;
    end
    if (i_gain_cal_done) begin
      next_s.gain_ovf = 1'b0;
      if (s.gain_ovf || (i_gain_cal_active && i_filter_ovf)) begin
        set_v[`ADEM_B_CONV] = s.erren[`ADEM_B_CONV];
      end else begin
        next_s.gain_load = 1'b1;
      end
    end

    // Input and reference range
    if (s.erren[`ADEM_B_POS_RANGE] && (i_pos_over || i_pos_under)) begin
      set_v[`ADEM_B_POS_RANGE] = 1'b1;
    end
    if (s.erren[`ADEM_B_NEG_RANGE] && (i_neg_over || i_neg_under)) begin
      set_v[`ADEM_B_NEG_RANGE] = 1'b1;
    end
    if (s.erren[`ADEM_B_REF_RANGE] && (i_refp_over || i_refm_under)) begin
      set_v[`ADEM_B_REF_RANGE] = 1'b1;
    end

    // Locked register access
    if (s.erren[`ADEM_B_LOCK] && busy) begin
      set_v[`ADEM_B_LOCK] = 1'b1;
    end

    // Main clock monitor
    if (s.erren[`ADEM_B_CLKMON]) begin
      if (s.pres == PRES_LAST) begin
        next_s.pres = 8'h00;
        next_s.mclk_cnt = s.mclk_cnt + 16'h0001;
      end else begin
        next_s.pres = s.pres + 8'h01;
      end
    end else begin
      next_s.pres = 8'h00;
    end

    // End of a serial frame
    if (s.frame == adem_pkg::ADEM_DONE) begin
      if (s.erren[`ADEM_B_SCLK] && lif.cnt[2:0] != 3'h0) begin
        set_v[`ADEM_B_SCLK] = 1'b1;
      end
      if (s.erren[`ADEM_B_RD] && has_cmd && is_rd
          && !adem_pkg::adem_readable(addr)) begin
        set_v[`ADEM_B_RD] = 1'b1;
      end
      if (s.erren[`ADEM_B_WR] && has_cmd && !is_rd
          && !adem_pkg::adem_writable(addr)) begin
        set_v[`ADEM_B_WR] = 1'b1;
      end
      if (wr_ok && addr == `ADEM_ADDR_ERROR) begin
        clr_v = lif.data;
      end
      if (wr_ok && addr == `ADEM_ADDR_ERREN) begin
        next_s.erren = lif.data & `ADEM_ERREN_MASK;
      end
    end

    // Flags latch; a set in the clearing cycle wins
    next_s.err = ((s.err & ~clr_v) | set_v) & `ADEM_ERR_MASK;
    next_s.summary = |next_s.err;

    // Read image, frozen while a frame is open
    if (s.cs_s2 && s.frame == adem_pkg::ADEM_IDLE) begin
      if (busy) begin
        next_s.image = '0;
      end else begin
        next_s.image[`ADEM_ADDR_STATUS] = {15'h0000, s.summary};
        next_s.image[`ADEM_ADDR_ERROR] = s.err;
        next_s.image[`ADEM_ADDR_ERREN] = s.erren;
        next_s.image[`ADEM_ADDR_MCLKCNT] = s.mclk_cnt;
        next_s.image[`ADEM_ADDR_RESULT] = s.result;
      end
    end
  end

  // ========================================================
  // State register
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '{frame: adem_pkg::ADEM_IDLE,
             cs_s1: 1'b1,
             cs_s2: 1'b1,
             erren: `ADEM_ERREN_RESET,
             default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ========================================================
  // Outputs
  assign lif.image = s.image;
  assign o_result = s.result;
  assign o_offset_load = s.ofs_load;
  assign o_gain_load = s.gain_load;
  assign o_error_flags = s.err;
  assign o_error_enable = s.erren;
  assign o_summary_err = s.summary;
  assign o_mclk_count = s.mclk_cnt;
  assign o_regs_locked = s.err[`ADEM_B_LOCK];

endmodule : adem_monitor

// ==== tb/adem_monitor_chk.sv ====
// Port assertions of the ADC diagnostic error monitor
`timescale 1ns/10ps
module adem_monitor_chk #(
  parameter int MCLK_DIV = 131
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Conditions
  input wire logic i_ref_ext_sel,
  input wire logic i_ref_low,
  input wire logic i_ref_open,
  input wire logic i_filter_ovf,
  input wire logic i_data_update,
  input wire logic i_offset_cal_done,
  input wire logic [15:0] i_offset_coef,
  input wire logic i_pos_over,
  input wire logic i_refp_over,
  input wire logic i_refm_under,
  input wire logic i_cal_busy,
  // Status
  input wire logic [15:0] o_result,
  input wire logic o_offset_load,
  input wire logic [15:0] o_error_flags,
  input wire logic [15:0] o_error_enable,
  input wire logic o_summary_err,
  input wire logic [15:0] o_mclk_count,
  input wire logic o_regs_locked
);
  default clocking dc @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);
  // ========================================================
  // Cycles since the clock count last moved
  logic [15:0] prev;
  logic [15:0] since;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev <= 16'h0;
      since <= 16'h0;
    end else begin
      prev <= o_mclk_count;
      since <= (o_mclk_count != prev) ? 16'h0 :
        ((&since) ? since : since + 16'h1);
    end
  end
  // ========================================================
  // Properties
  sequence s_ref_fault;
    o_error_enable[0] && i_ref_ext_sel && (i_ref_low || i_ref_open);
  endsequence
  sequence s_ovf_update;
    o_error_enable[1] && i_filter_ovf ##1 i_data_update;
  endsequence
  property p_ref_loss;
    s_ref_fault |-> ##[1:2] o_error_flags[0];
  endproperty
  property p_summary;
    o_error_flags[0] |-> ##[0:1] o_summary_err;
  endproperty
  property p_pos_range;
    o_error_enable[2] && i_pos_over |-> ##[1:2] o_error_flags[2];
  endproperty
  property p_range_gate;
    $rose(o_error_flags[2]) |-> $past(o_error_enable[2]);
  endproperty
  property p_ref_range;
    o_error_enable[4] && (i_refp_over || i_refm_under)
      |-> ##[1:2] o_error_flags[4];
  endproperty
  property p_clamp;
    s_ovf_update |-> ##[1:2] (o_result == 16'hffff && o_error_flags[1]);
  endproperty
  property p_ofs_keep;
    i_offset_cal_done && (i_offset_coef < 16'h07ff ||
      i_offset_coef > 16'hf7ff) |-> ##1 !o_offset_load [*3];
  endproperty
  property p_lock_set;
    o_error_enable[8] && i_cal_busy |-> ##[1:2] o_regs_locked;
  endproperty
  property p_lock_drop;
    $changed(o_error_enable) |-> !$past(o_regs_locked);
  endproperty
  property p_clk_step;
    (o_mclk_count != prev) |-> o_mclk_count == prev + 16'h1;
  endproperty
  property p_clk_gap;
    (o_mclk_count != prev) |-> since >= MCLK_DIV - 1;
  endproperty
  a_ref_loss: assert property (p_ref_loss)
    else $error("reference loss flag not raised");
  a_summary: assert property (p_summary)
    else $error("summary bit not raised");
  a_pos_range: assert property (p_pos_range)
    else $error("positive input range flag not raised");
  a_range_gate: assert property (p_range_gate)
    else $error("range flag raised while disabled");
  a_ref_range: assert property (p_ref_range)
    else $error("reference range flag not raised");
  a_clamp: assert property (p_clamp)
    else $error("overflow result not clamped");
  a_ofs_keep: assert property (p_ofs_keep)
    else $error("bad offset coefficient committed");
  a_lock_set: assert property (p_lock_set)
    else $error("lock flag not raised while busy");
  a_lock_drop: assert property (p_lock_drop)
    else $error("enable changed while locked");
  a_clk_step: assert property (p_clk_step)
    else $error("clock count did not step by one");
  a_clk_gap: assert property (p_clk_gap)
    else $error("clock count stepped too early");
endmodule : adem_monitor_chk

bind adem_monitor adem_monitor_chk #(.MCLK_DIV(MCLK_DIV)) u_chk (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_ref_ext_sel(i_ref_ext_sel),
  .i_ref_low(i_ref_low), .i_ref_open(i_ref_open),
  .i_filter_ovf(i_filter_ovf), .i_data_update(i_data_update),
  .i_offset_cal_done(i_offset_cal_done), .i_offset_coef(i_offset_coef),
  .i_pos_over(i_pos_over), .i_refp_over(i_refp_over),
  .i_refm_under(i_refm_under), .i_cal_busy(i_cal_busy),
  .o_result(o_result), .o_offset_load(o_offset_load),
  .o_error_flags(o_error_flags), .o_error_enable(o_error_enable),
  .o_summary_err(o_summary_err), .o_mclk_count(o_mclk_count),
  .o_regs_locked(o_regs_locked)
);

// ==== tb/adem_host.sv ====
// Host controller model driving the serial pins
`timescale 1ns/10ps
module adem_host (
  // Serial pins
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi,
  input wire logic i_sdo
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end
  // One framed transfer: command byte, data word, n clock pulses
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
      input int n, output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, wd};
    rd = 16'h0;
    o_cs_n = 1'b0;
    #500;
    for (int k = 0; k < n; k++) begin
      o_sdi = sh[23];
      sh = {sh[22:0], 1'b0};
      #16;
      if (k >= 8 && k < 24) begin
        rd = {rd[14:0], i_sdo};
      end
      o_sclk = 1'b1;
      #16;
      o_sclk = 1'b0;
    end
    #200;
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #1000;
  endtask : xfer
endmodule : adem_host

// ==== tb/adem_monitor_bench.sv ====
// Self-checking bench of the ADC diagnostic error monitor
`timescale 1ns/10ps
`include "adem_cfg.svh"
module adem_monitor_bench;
  // ========================================================
  // Stimulus and observed signals
  logic i_mclk, i_rstn, sclk, cs_n, sdi, sdo, oe;
  logic ext, rlow, ropen, ovf, unf, upd, mv, mb;
  logic ocd, gact, gdone, ldg, calb, seqb, sum, oload, gload, lck;
  logic [5:0] rng;
  logic [15:0] raw, coef, res, flg, ena, cnt, rdv;
  int miscompares, compares;

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  adem_monitor #(.MCLK_DIV(4), .SAT_RUN(20)) dut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe_n(oe), .i_ref_ext_sel(ext),
    .i_ref_low(rlow), .i_ref_open(ropen), .i_filter_ovf(ovf),
    .i_filter_unf(unf), .i_data_update(upd), .i_raw_result(raw),
    .i_mod_valid(mv), .i_mod_bit(mb), .i_offset_cal_done(ocd),
    .i_offset_coef(coef), .i_gain_cal_active(gact),
    .i_gain_cal_done(gdone), .i_pos_over(rng[0]), .i_pos_under(rng[1]),
    .i_neg_over(rng[2]), .i_neg_under(rng[3]), .i_refp_over(rng[4]),
    .i_refm_under(rng[5]), .i_defaults_loading(ldg), .i_cal_busy(calb),
    .i_single_seq_busy(seqb), .o_result(res), .o_offset_load(oload),
    .o_gain_load(gload), .o_error_flags(flg), .o_error_enable(ena),
    .o_summary_err(sum), .o_mclk_count(cnt), .o_regs_locked(lck)
  );
  adem_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo));

  // ========================================================
  // Shared tasks
  task automatic chk(input string n, input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : cyc
  task automatic wr(input logic [6:0] a, input logic [15:0] d, input int n);
    host.xfer({1'b0, a}, d, n, rdv);
  endtask : wr
  task automatic rd(input logic [6:0] a);
    host.xfer({1'b1, a}, 16'h0, 24, rdv);
  endtask : rd
  task automatic watch3(output int no, output int ng);
    no = 0;
    ng = 0;
    repeat (3) begin
      cyc(1);
      no += int'(oload === 1'b1);
      ng += int'(gload === 1'b1);
    end
  endtask : watch3
  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // ========================================================
  // Scenarios
  task automatic t_lock;
    chk("enable reset", ena, 16'h0100);
    for (int s = 0; s < 3; s++) begin
      cyc(1);
      {ldg, calb, seqb} <= 3'h4 >> s;
      cyc(3);
      chk("locked", 16'(lck), 16'h0001);
      wr(`ADEM_ADDR_ERREN, 16'h03ff, 24);
      chk("busy write", ena, 16'h0100);
      cyc(1);
      {ldg, calb, seqb} <= 3'h0;
      wr(`ADEM_ADDR_ERREN, 16'h03ff, 24);
      chk("locked write", ena, 16'h0100);
      wr(`ADEM_ADDR_ERROR, 16'h0100, 24);
      chk("lock clear", 16'(lck), 16'h0000);
    end
    wr(`ADEM_ADDR_ERREN, 16'h02ff, 24);
    cyc(1);
    calb <= 1'b1;
    cyc(3);
    chk("lock off", 16'(lck), 16'h0000);
    calb <= 1'b0;
    wr(`ADEM_ADDR_ERREN, 16'h03ff, 24);
    chk("enable all", ena, 16'h03ff);
  endtask : t_lock

  task automatic t_range;
    for (int k = 0; k < 6; k++) begin
      cyc(1);
      rng <= 6'h01 << k;
      cyc(2);
      rng <= 6'h00;
      cyc(4);
      chk("range flag", flg, 16'h0001 << (2 + k / 2));
      wr(`ADEM_ADDR_ERROR, flg, 24);
      chk("range clear", flg, 16'h0000);
    end
    wr(`ADEM_ADDR_ERREN, 16'h03e3, 24);
    cyc(1);
    rng <= 6'h3f;
    cyc(3);
    rng <= 6'h00;
    chk("range off", flg, 16'h0000);
    wr(`ADEM_ADDR_ERREN, 16'h03ff, 24);
  endtask : t_range

  task automatic t_ref;
    cyc(1);
    ext <= 1'b1;
    ropen <= 1'b1;
    cyc(2);
    ropen <= 1'b0;
    rd(`ADEM_ADDR_STATUS);
    chk("status", rdv, 16'h0001);
    rd(`ADEM_ADDR_ERROR);
    chk("error read", rdv, 16'h0001);
    wr(`ADEM_ADDR_ERROR, rdv, 24);
    chk("ref clear", flg, 16'h0000);
    cyc(1);
    ext <= 1'b0;
    rlow <= 1'b1;
    cyc(3);
    rlow <= 1'b0;
    chk("internal ref", flg, 16'h0000);
  endtask : t_ref

  task automatic t_spi;
    wr(`ADEM_ADDR_ERREN, 16'h0000, 23);
    chk("short write", ena, 16'h03ff);
    chk("sclk flag", flg, 16'h0020);
    rd(7'h05);
    chk("undefined read", rdv, 16'h0000);
    chk("sdo idle", 16'(oe), 16'h0001);
    wr(`ADEM_ADDR_MCLKCNT, 16'h1234, 24);
    chk("access flags", flg, 16'h00e0);
    wr(`ADEM_ADDR_ERROR, 16'h00e0, 24);
    rd(`ADEM_ADDR_ERREN);
    chk("enable read", rdv, 16'h03ff);
  endtask : t_spi

  task automatic t_conv;
    logic [15:0] tbl [4] = '{16'h07fe, 16'h07ff, 16'hf7ff, 16'hf800};
    int n;
    int m;
    for (int g = 0; g < 2; g++) begin
      cyc(1);
      gact <= 1'b1;
      ovf <= (g == 0);
      cyc(1);
      ovf <= 1'b0;
      gdone <= 1'b1;
      cyc(1);
      {gact, gdone} <= 2'h0;
      watch3(n, m);
      chk("gain load", 16'(m), g ? 16'h0001 : 16'h0000);
      chk("gain flag", flg, g ? 16'h0000 : 16'h0002);
      wr(`ADEM_ADDR_ERROR, 16'h0002, 24);
    end
    for (int u = 0; u < 2; u++) begin
      cyc(1);
      {ovf, unf} <= u ? 2'h1 : 2'h2;
      cyc(1);
      upd <= 1'b1;
      cyc(1);
      {ovf, unf} <= 2'h0;
      upd <= 1'b0;
      cyc(3);
      chk("clamp", res, u ? 16'h0000 : 16'hffff);
      chk("filter flag", flg, 16'h0002);
      wr(`ADEM_ADDR_ERROR, 16'h0002, 24);
    end
    for (int j = 0; j < 4; j++) begin
      cyc(1);
      coef <= tbl[j];
      ocd <= 1'b1;
      cyc(1);
      ocd <= 1'b0;
      watch3(n, m);
      chk("offset load", 16'(n), (j % 3) ? 16'h0001 : 16'h0000);
      chk("offset flag", flg, (j % 3) ? 16'h0000 : 16'h0002);
      wr(`ADEM_ADDR_ERROR, 16'h0002, 24);
    end
    for (int r = 19; r < 21; r++) begin
      cyc(1);
      mb <= 1'b0;
      mv <= 1'b1;
      cyc(1);
      mb <= 1'b1;
      cyc(r);
      mv <= 1'b0;
      cyc(2);
      chk("before update", flg, 16'h0000);
      upd <= 1'b1;
      cyc(1);
      upd <= 1'b0;
      cyc(3);
      chk("saturation", flg, (r == 20) ? 16'h0002 : 16'h0000);
      wr(`ADEM_ADDR_ERROR, 16'h0002, 24);
    end
  endtask : t_conv

  task automatic t_clk;
    logic [15:0] c;
    int k;
    c = cnt;
    k = 0;
    while (cnt === c && k < 20) begin
      cyc(1);
      k++;
    end
    if (k == 20) begin
      miscompares++;
      tally_and_finish();
    end
    c = cnt;
    cyc(40);
    chk("clock count", cnt, c + 16'h000a);
    wr(`ADEM_ADDR_ERREN, 16'h01ff, 24);
    c = cnt;
    cyc(12);
    chk("clock count off", cnt, c);
  endtask : t_clk

  // ========================================================
  // Main sequence and watchdog
  initial begin
    {i_rstn, ext, rlow, ropen, ovf, unf, upd, mv, mb} = 9'h000;
    {ocd, gact, gdone, calb, seqb, rng} = 11'h000;
    ldg = 1'b1;
    raw = 16'h1234;
    coef = 16'h0000;
    cyc(3);
    i_rstn <= 1'b1;
    cyc(3);
    t_lock();
    $display("lock test done");
    t_range();
    $display("range test done");
    t_ref();
    $display("reference test done");
    t_spi();
    $display("serial test done");
    t_conv();
    $display("conversion test done");
    t_clk();
    $display("clock monitor test done");
    tally_and_finish();
  end
  initial begin
    #4000000;
    miscompares++;
    tally_and_finish();
  end
endmodule : adem_monitor_bench
